// *** common/tsc_pkg.sv ***
// tsc_pkg: register numbers, field positions, reset values and carriers
// for the tile status/control register group.
// assumes a single core clock domain; register numbers are status numbers.
package tsc_pkg;

    localparam int REG_NUM_W = 8;
    localparam logic [REG_NUM_W-1:0] REG_TILE_CONTROL     = 8'h02;
    localparam logic [REG_NUM_W-1:0] REG_TILE_BOOT_STATUS = 8'h03;
    localparam logic [REG_NUM_W-1:0] REG_SECURITY_CONFIG  = 8'h05;
    localparam logic [REG_NUM_W-1:0] REG_RING_OSC_CONTROL = 8'h06;
    localparam logic [REG_NUM_W-1:0] REG_RING_OSC_VALUE0  = 8'h07;
    localparam int RING_OSC_COUNT = 4;
    localparam int RING_OSC_CNT_W = 16;

    // status resource code software combines with the register number
    localparam logic [7:0] PS_RESOURCE_CODE = 8'h0b;

    // tile control fields
    localparam int TC_TXDLY_LSB   = 18;
    localparam int TC_TXDLY_W     = 8;
    localparam int TC_TXDIV_LSB   = 9;
    localparam int TC_TXDIV_W     = 9;
    localparam int TC_RGMII_EN    = 8;
    localparam int TC_DYN_MODE    = 5;
    localparam int TC_DIV_EN      = 4;
    localparam int TC_UTMI_SEL    = 2;
    localparam int TC_ULPI_EN     = 1;
    localparam logic [31:0] TC_WR_MASK  = 32'h03ff_ff36;
    localparam logic [31:0] TC_RESET    = 32'h0000_0000;

    // boot status fields
    localparam int BS_PROC_LSB    = 16;
    localparam int BS_OVERRIDE    = 8;
    localparam int BS_CORE1_OFF   = 5;
    localparam int BS_SKIP_POLL   = 4;
    localparam int BS_BOOT_RAM    = 3;
    localparam int BS_BOOT_JTAG   = 2;
    localparam int BS_PLL_LSB     = 0;

    // security config fields
    localparam int SC_LOCK        = 31;
    localparam int SC_GDBG_DIS    = 14;
    localparam int SC_OTP_LOCKALL = 12;
    localparam int SC_OTP_LOCK_LSB = 8;
    localparam int SC_OTP_REDUN   = 7;
    localparam int SC_BOOT_OTP    = 5;
    localparam int SC_JTAG_CFG_DIS = 4;
    localparam int SC_JTAG_DBG_DIS = 0;
    localparam logic [31:0] SC_WR_MASK  = 32'h8000_5fb1;
    localparam logic [31:0] SC_RESET    = 32'h0000_0000;

    // ring oscillator control fields
    localparam int RO_PERIPH_EN   = 0;
    localparam int RO_CORE_EN     = 1;
    localparam logic [31:0] RO_WR_MASK  = 32'h0000_0003;
    localparam logic [31:0] RO_RESET    = 32'h0000_0000;

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [REG_NUM_W-1:0]  num;
        logic [31:0]           wdata;
    } tsc_req_t;

    typedef struct packed {
        logic [7:0] proc_num;
        logic       override;
        logic       core1_off;
        logic       skip_poll;
        logic       boot_ram;
        logic       boot_jtag;
        logic [1:0] pll_mode;
    } tsc_boot_t;

endpackage : tsc_pkg

// *** verilog/tsc_ring_osc.sv ***
// tsc_ring_osc: one free-running oscillator and its 16-bit counter.
// assumes ring_clk comes from the oscillator cell itself (a gated free
// ring in silicon); the count is not reset, only the run enable is synced.
`timescale 1ns/1ns
module tsc_ring_osc
    import tsc_pkg::*;
#(
    parameter int CNT_W = RING_OSC_CNT_W
) (
    input  wire logic             ring_clk,
    input  wire logic             run,
    output logic [CNT_W-1:0] count
);
    logic run_s1_q;
    logic run_s2_q;
    logic [CNT_W-1:0] count_q = '0;

    always_ff @(posedge ring_clk) begin
        run_s1_q <= run;
        run_s2_q <= run_s1_q;
    end

    // no reset: count survives system reset
    always_ff @(posedge ring_clk) begin
        if (run_s2_q) begin
            count_q <= count_q + 1'b1;
        end
    end

    assign count = count_q;

endmodule : tsc_ring_osc

// *** verilog/tsc_regs.sv ***
// tsc_regs: tile status/control register group on the status access port.
// assumes status read/write requests from the tile's instruction stream in
// the mclk domain; ring oscillators run from their own cell clocks.
// What this block does
// - tx data delay field, resets zero
// - tx clock high at divider, low at half
// - rgmii enable connects periph ports, resets zero
// - dynamic mode divides only when threads paused
// - divider enable divides pll clock
// - mode bit: one utmi, zero ulpi
// - ulpi enable activates ulpi support
// - boot status read-only, processor number field
// - boot status reports strap flags, pll mode
// - lock bit blocks further security writes
// - global debug disable blocks global debug
// - jtag debug disable blocks debug tap
// - otp lock-all bit and per-sector locks
// - otp redundancy and boot-from-otp override
// - deny jtag access to pll/boot config
// - security word loaded from otp copy
// - four ring oscillators started, stopped by software
// - bit1 core, bit0 peripheral oscillator enables
// - oscillators asynchronous, usable as random source
// - sixteen-bit counters survive system reset
`timescale 1ns/1ns
module tsc_regs
    import tsc_pkg::*;
#(
    parameter int DLY_MAX = 1 << TC_TXDLY_W
) (
    input  wire logic                  mclk,
    input  wire logic                  srst,
    input  wire tsc_req_t              req,
    output logic [31:0]                rdata,
    output logic                       rvalid,
    output logic                       wr_refused,
    input  wire tsc_boot_t             boot_straps,
    input  wire logic                  otp_load,
    input  wire logic [31:0]           otp_word,
    input  wire logic                  pll_clk,
    input  wire logic                  threads_paused,
    input  wire logic [RING_OSC_COUNT-1:0] ring_clk,
    input  wire logic                  rgmii_txd_in,
    output logic                       rgmii_tx_clk,
    output logic                       rgmii_txd,
    output logic                       rgmii_periph_en,
    output logic                       clk_div_active,
    output logic                       usb_utmi_mode,
    output logic                       ulpi_hw_en,
    output logic                       global_debug_block,
    output logic                       jtag_tap_block,
    output logic                       jtag_cfg_block,
    output logic                       otp_lock_all,
    output logic [3:0]                 otp_sector_lock,
    output logic                       otp_redundancy_en,
    output logic                       boot_from_otp,
    output logic [1:0]                 ring_osc_en
);
    logic [31:0]     tile_control_q;
    logic [31:0]     security_config_q;
    logic [31:0]     ring_osc_control_q;
    tsc_boot_t       boot_q;
    logic            boot_taken_q;
    logic [31:0]     rdata_d;
    logic [RING_OSC_CNT_W-1:0] osc_cnt [RING_OSC_COUNT];

    // strap pins are asynchronous to mclk: two flops before anything looks
    tsc_boot_t       boot_s1_q;
    tsc_boot_t       boot_s2_q;

    always_ff @(posedge mclk) begin
        boot_s1_q <= boot_straps;
        boot_s2_q <= boot_s1_q;
    end

    // snapshot taken once after reset release; later strap moves are ignored
    always_ff @(posedge mclk) begin
        if (srst) begin
            boot_taken_q <= 1'b0;
        end else if (!boot_taken_q) begin
            boot_taken_q <= 1'b1;
            boot_q       <= boot_s2_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            tile_control_q <= TC_RESET;
        end else if (req.wr && req.num == REG_TILE_CONTROL) begin
            tile_control_q <= req.wdata & TC_WR_MASK;
        end
    end

    // otp load wins over a software write in the same cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            security_config_q <= SC_RESET;
        end else if (otp_load) begin
            security_config_q <= otp_word & SC_WR_MASK;
        end else if (req.wr && req.num == REG_SECURITY_CONFIG
                     && !security_config_q[SC_LOCK]) begin
            security_config_q <= req.wdata & SC_WR_MASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ring_osc_control_q <= RO_RESET;
        end else if (req.wr && req.num == REG_RING_OSC_CONTROL) begin
            ring_osc_control_q <= req.wdata & RO_WR_MASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            wr_refused <= 1'b0;
        end else begin
            wr_refused <= req.wr && req.num == REG_SECURITY_CONFIG
                          && security_config_q[SC_LOCK];
        end
    end

    // counters are sampled raw: only stable once stopped for ten cycles
    always_comb begin
        rdata_d = '0;
        unique case (req.num)
            REG_TILE_CONTROL:     rdata_d = tile_control_q;
            REG_TILE_BOOT_STATUS: begin
                rdata_d[BS_PROC_LSB +: 8] = boot_q.proc_num;
                rdata_d[BS_OVERRIDE]      = boot_q.override;
                rdata_d[BS_CORE1_OFF]     = boot_q.core1_off;
                rdata_d[BS_SKIP_POLL]     = boot_q.skip_poll;
                rdata_d[BS_BOOT_RAM]      = boot_q.boot_ram;
                rdata_d[BS_BOOT_JTAG]     = boot_q.boot_jtag;
                rdata_d[BS_PLL_LSB +: 2]  = boot_q.pll_mode;
            end
            REG_SECURITY_CONFIG:  rdata_d = security_config_q;
            REG_RING_OSC_CONTROL: rdata_d = ring_osc_control_q;
            REG_RING_OSC_VALUE0,
            REG_RING_OSC_VALUE0 + 8'h01,
            REG_RING_OSC_VALUE0 + 8'h02,
            REG_RING_OSC_VALUE0 + 8'h03: begin
                rdata_d[RING_OSC_CNT_W-1:0] =
                    osc_cnt[2'(req.num - REG_RING_OSC_VALUE0)];
            end
            default:              rdata_d = '0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata  <= '0;
            rvalid <= 1'b0;
        end else begin
            rdata  <= req.rd ? rdata_d : '0;
            rvalid <= req.rd;
        end
    end

    // 0,1 core cell/wire; 2,3 peripheral cell/wire
    genvar gi;
    generate
        for (gi = 0; gi < RING_OSC_COUNT; gi++) begin : g_osc
            tsc_ring_osc #(.CNT_W(RING_OSC_CNT_W)) u_osc (
                .ring_clk (ring_clk[gi]),
                .run      (gi < 2 ? ring_osc_control_q[RO_CORE_EN]
                                  : ring_osc_control_q[RO_PERIPH_EN]),
                .count    (osc_cnt[gi])
            );
        end
    endgenerate

    // tile control outputs, registered
    // dynamic mode gates the divider on paused threads, static does not
    always_ff @(posedge mclk) begin
        if (srst) begin
            rgmii_periph_en <= 1'b0;
            clk_div_active  <= 1'b0;
            usb_utmi_mode   <= 1'b0;
            ulpi_hw_en      <= 1'b0;
        end else begin
            rgmii_periph_en <= tile_control_q[TC_RGMII_EN];
            clk_div_active  <= tile_control_q[TC_DIV_EN]
                && (!tile_control_q[TC_DYN_MODE] || threads_paused);
            usb_utmi_mode   <= tile_control_q[TC_UTMI_SEL];
            ulpi_hw_en      <= tile_control_q[TC_ULPI_EN];
        end
    end

    // security outputs follow the register a cycle later, so an otp load acts two cycles on
    // and an otp load overwrites even a locked register, blocks and lock bit alike
    always_ff @(posedge mclk) begin
        if (srst) begin
            global_debug_block <= 1'b0;
            jtag_tap_block     <= 1'b0;
            jtag_cfg_block     <= 1'b0;
            otp_lock_all       <= 1'b0;
            otp_sector_lock    <= '0;
            otp_redundancy_en  <= 1'b0;
            boot_from_otp      <= 1'b0;
        end else begin
            global_debug_block <= security_config_q[SC_GDBG_DIS];
            jtag_tap_block     <= security_config_q[SC_JTAG_DBG_DIS];
            jtag_cfg_block     <= security_config_q[SC_JTAG_CFG_DIS];
            otp_lock_all       <= security_config_q[SC_OTP_LOCKALL];
            otp_sector_lock    <= security_config_q[SC_OTP_LOCK_LSB +: 4];
            otp_redundancy_en  <= security_config_q[SC_OTP_REDUN];
            boot_from_otp      <= security_config_q[SC_BOOT_OTP];
        end
    end

    // peripheral pair on bit 0, core pair on bit 1
    always_ff @(posedge mclk) begin
        if (srst) begin
            ring_osc_en <= '0;
        end else begin
            ring_osc_en <= ring_osc_control_q[RO_CORE_EN:RO_PERIPH_EN];
        end
    end

    // tx settings cross to pll_clk as one word under a toggle handshake:
    // a new word is only offered once the last one was taken, so the
    // divider and delay never arrive torn. later writes wait as pending.
    localparam int XFER_W = 1 + TC_TXDLY_W + TC_TXDIV_W;

    logic [XFER_W-1:0]     xfer_word_q;
    logic                  xfer_req_q;
    logic                  xfer_pend_q;
    logic                  ack_s1_q;
    logic                  ack_s2_q;
    logic                  req_s1_q;
    logic                  req_s2_q;
    logic                  req_s3_q;
    logic [TC_TXDIV_W-1:0] txdiv_q;
    logic [TC_TXDIV_W-1:0] txcnt_q;
    logic [TC_TXDLY_W-1:0] txdly_q;
    logic                  txen_q;
    logic [DLY_MAX-1:0]    txd_pipe_q;

    // reset leaves a pending word so the pll side learns the reset values
    always_ff @(posedge mclk) begin
        if (srst) begin
            xfer_req_q  <= 1'b0;
            xfer_pend_q <= 1'b1;
            xfer_word_q <= '0;
        end else if (xfer_pend_q && xfer_req_q == ack_s2_q) begin
            xfer_req_q  <= ~xfer_req_q;
            xfer_pend_q <= req.wr && req.num == REG_TILE_CONTROL;
            xfer_word_q <= {tile_control_q[TC_RGMII_EN],
                            tile_control_q[TC_TXDLY_LSB +: TC_TXDLY_W],
                            tile_control_q[TC_TXDIV_LSB +: TC_TXDIV_W]};
        end else if (req.wr && req.num == REG_TILE_CONTROL) begin
            xfer_pend_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        ack_s1_q <= req_s3_q;
        ack_s2_q <= ack_s1_q;
    end

    // pll side: the word has been still for two pll edges when taken
    always_ff @(posedge pll_clk) begin
        req_s1_q <= xfer_req_q;
        req_s2_q <= req_s1_q;
        req_s3_q <= req_s2_q;
    end

    always_ff @(posedge pll_clk) begin
        if (req_s2_q != req_s3_q) begin
            txen_q  <= xfer_word_q[XFER_W-1];
            txdly_q <= xfer_word_q[TC_TXDIV_W +: TC_TXDLY_W];
            txdiv_q <= xfer_word_q[TC_TXDIV_W-1:0];
        end
    end

    always_ff @(posedge pll_clk) begin
        if (!txen_q || txcnt_q >= txdiv_q) begin
            txcnt_q <= '0;
        end else begin
            txcnt_q <= txcnt_q + 1'b1;
        end
    end

    // disabled tx clock parks low
    always_ff @(posedge pll_clk) begin
        if (!txen_q) begin
            rgmii_tx_clk <= 1'b0;
        end else if (txcnt_q == txdiv_q) begin
            rgmii_tx_clk <= 1'b1;
        end else if (txcnt_q == (txdiv_q >> 1)) begin
            rgmii_tx_clk <= 1'b0;
        end
    end

    // delay tap: one flop per pll cycle of delay, zero bypasses the pipe
    always_ff @(posedge pll_clk) begin
        txd_pipe_q <= {txd_pipe_q[DLY_MAX-2:0], rgmii_txd_in};
        rgmii_txd  <= (txdly_q == '0) ? rgmii_txd_in
                                      : txd_pipe_q[txdly_q - 1'b1];
    end

endmodule : tsc_regs

// *** tb/tsc_regs_checker.sv ***
// tsc_regs_checker: port-level properties of the status register group.
// assumes binding onto tsc_regs; one mclk domain, srst synchronous.
`timescale 1ns/1ns
module tsc_regs_checker
    import tsc_pkg::*;
(
    input wire logic        mclk,
    input wire logic        srst,
    input wire tsc_req_t    req,
    input wire logic [31:0] rdata,
    input wire logic        rvalid,
    input wire logic        wr_refused,
    input wire logic        otp_load,
    input wire logic [31:0] otp_word,
    input wire logic        rgmii_periph_en,
    input wire logic        global_debug_block,
    input wire logic [1:0]  ring_osc_en
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    rd_answer_a: assert property (req.rd |=> rvalid)
        else $error("read not answered");
    rdata_idle_a: assert property (!rvalid |-> rdata == 32'h0)
        else $error("read data not zero when idle");
    refuse_cause_a: assert property (wr_refused |-> $past(req.wr)
        && $past(req.num) == REG_SECURITY_CONFIG) else $error("refusal without write");
    tile_resv_a: assert property (rvalid && $past(req.num) == REG_TILE_CONTROL
        |-> (rdata & ~TC_WR_MASK) == 32'h0) else $error("tile reserved bits set");
    boot_resv_a: assert property (rvalid && $past(req.num) == REG_TILE_BOOT_STATUS
        |-> rdata[31:24] == 8'h0 && rdata[15:9] == 7'h0) else $error("boot reserved set");
    ring_en_a: assert property (req.wr && req.num == REG_RING_OSC_CONTROL
        |-> ##2 ring_osc_en == $past(req.wdata[1:0], 2)) else $error("ring enable wrong");
    rgmii_en_a: assert property (req.wr && req.num == REG_TILE_CONTROL
        |-> ##2 rgmii_periph_en == $past(req.wdata[8], 2)) else $error("rgmii enable wrong");
    otp_copy_a: assert property (otp_load
        |-> ##2 global_debug_block == $past(otp_word[14], 2)) else $error("otp copy wrong");
    refused_c: cover property (wr_refused);
    otp_c: cover property (otp_load);
    ring_c: cover property (ring_osc_en == 2'h3);
endmodule : tsc_regs_checker

bind tsc_regs tsc_regs_checker tsc_regs_checker_inst (.mclk(mclk), .srst(srst), .req(req),
    .rdata(rdata), .rvalid(rvalid), .wr_refused(wr_refused), .otp_load(otp_load),
    .otp_word(otp_word), .rgmii_periph_en(rgmii_periph_en),
    .global_debug_block(global_debug_block), .ring_osc_en(ring_osc_en));

// *** tb/tb.sv ***
// tb: directed bench for the tsc_regs status register group.
// assumes tsc_regs on mclk at 20 MHz, free pll clock and oscillator clocks.
`timescale 1ns/1ns
module tb
    import tsc_pkg::*;
;
    logic        mclk, rvalid, wr_refused, rgmii_tx_clk, rgmii_txd, rgmii_periph_en;
    logic        clk_div_active, usb_utmi_mode, ulpi_hw_en, global_debug_block;
    logic        jtag_tap_block, jtag_cfg_block, otp_lock_all, otp_redundancy_en;
    logic        boot_from_otp;
    logic [3:0]  otp_sector_lock;
    logic [1:0]  ring_osc_en;
    logic [31:0] rdata;
    logic        srst = 1'b1, otp_load = 1'b0, pll_clk = 1'b0, threads_paused = 1'b0;
    logic        txd_in = 1'b0;
    logic [31:0] otp_word = 32'h0, v;
    logic [3:0]  ring_clk = 4'h0;
    tsc_req_t    req = '0;
    tsc_boot_t   boot_straps = '{8'h5a, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 2'h2};
    logic [15:0] cnt_a[4];
    int          error_cnt = 0, num_checks = 0;

    tsc_regs tsc_regs_inst (.mclk(mclk), .srst(srst), .req(req), .rdata(rdata),
        .rvalid(rvalid), .wr_refused(wr_refused), .boot_straps(boot_straps),
        .otp_load(otp_load), .otp_word(otp_word), .pll_clk(pll_clk),
        .threads_paused(threads_paused), .ring_clk(ring_clk), .rgmii_txd_in(txd_in),
        .rgmii_tx_clk(rgmii_tx_clk), .rgmii_txd(rgmii_txd), .rgmii_periph_en(rgmii_periph_en),
        .clk_div_active(clk_div_active), .usb_utmi_mode(usb_utmi_mode), .ulpi_hw_en(ulpi_hw_en),
        .global_debug_block(global_debug_block), .jtag_tap_block(jtag_tap_block),
        .jtag_cfg_block(jtag_cfg_block), .otp_lock_all(otp_lock_all),
        .otp_sector_lock(otp_sector_lock), .otp_redundancy_en(otp_redundancy_en),
        .boot_from_otp(boot_from_otp), .ring_osc_en(ring_osc_en));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial forever #5 pll_clk = ~pll_clk;
    // odd step keeps the oscillators out of phase with mclk
    always #3 ring_clk = ring_clk + 4'h1;

    task automatic check_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check_eq

    task automatic wr_reg(input logic [7:0] num, input logic [31:0] d);
        @(posedge mclk);
        #1 req = '{1'b1, 1'b0, num, d};
        @(posedge mclk);
        #1 req = '0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] num, output logic [31:0] d);
        @(posedge mclk);
        #1 req = '{1'b0, 1'b1, num, 32'h0};
        @(posedge mclk);
        #1 req = '0;
        check_eq({31'h0, rvalid}, 32'h1, "read valid");
        d = rdata;
    endtask : rd_reg

    task automatic do_reset();
        @(posedge mclk);
        #1 srst = 1'b1;
        repeat (12) @(posedge mclk);
        #1 srst = 1'b0;
    endtask : do_reset

    // pll cycles from a rising tx data input to the rising tx data output
    task automatic tx_lag(input logic [7:0] dly, output int lag);
        wr_reg(REG_TILE_CONTROL, {6'h0, dly, 18'h0_0700});
        repeat (4) @(posedge mclk);
        @(posedge pll_clk);
        #1 txd_in = 1'b1;
        lag = 0;
        while (rgmii_txd !== 1'b1 && lag < 300) begin
            @(posedge pll_clk);
            #1 lag++;
        end
        txd_in = 1'b0;
    endtask : tx_lag

    task automatic t_tile();
        int   n, h;
        logic p;
        rd_reg(REG_TILE_CONTROL, v);
        check_eq(v, 32'h0, "tile reset");
        wr_reg(REG_TILE_CONTROL, 32'hffff_ffff);
        rd_reg(REG_TILE_CONTROL, v);
        check_eq(v, 32'h03ff_ff36, "tile mask");
        check_eq({rgmii_periph_en, usb_utmi_mode, ulpi_hw_en, clk_div_active}, 4'he, "flags");
        threads_paused = 1'b1;
        repeat (2) @(posedge mclk);
        #1 check_eq({31'h0, clk_div_active}, 32'h1, "dynamic paused");
        threads_paused = 1'b0;
        wr_reg(REG_TILE_CONTROL, 32'h0000_0010);
        @(posedge mclk);
        #1 check_eq({ulpi_hw_en, usb_utmi_mode, clk_div_active}, 3'h1, "static div");
        // divide ratio four, programmed as three
        wr_reg(REG_TILE_CONTROL, 32'h0000_0700);
        repeat (4) @(posedge mclk);
        n = 0;
        h = 0;
        @(posedge pll_clk);
        #1 p = rgmii_tx_clk;
        repeat (40) begin
            @(posedge pll_clk);
            #1 if (rgmii_tx_clk === 1'b1 && p === 1'b0) n++;
            if (rgmii_tx_clk === 1'b1) h++;
            p = rgmii_tx_clk;
        end
        check_eq(n, 10, "tx clock rises");
        check_eq(h, 20, "tx clock high half");
        tx_lag(8'h00, n);
        check_eq(n, 1, "tx data no delay");
        tx_lag(8'h05, n);
        check_eq(n, 6, "tx data delay five");
    endtask : t_tile

    task automatic t_boot_unmapped();
        wr_reg(REG_TILE_BOOT_STATUS, 32'hffff_ffff);
        rd_reg(REG_TILE_BOOT_STATUS, v);
        check_eq(v, 32'h005a_0116, "boot status");
        wr_reg(8'h04, 32'hffff_ffff);
        rd_reg(8'h04, v);
        check_eq(v, 32'h0, "unmapped");
    endtask : t_boot_unmapped

    task automatic t_security();
        wr_reg(REG_SECURITY_CONFIG, 32'h7fff_ffff);
        rd_reg(REG_SECURITY_CONFIG, v);
        check_eq(v, 32'h0000_5fb1, "sec mask");
        check_eq({global_debug_block, jtag_tap_block, jtag_cfg_block, otp_lock_all,
            otp_sector_lock, otp_redundancy_en, boot_from_otp}, 10'h3ff, "sec flags");
        wr_reg(REG_SECURITY_CONFIG, 32'h8000_0000);
        wr_reg(REG_SECURITY_CONFIG, 32'h0000_0001);
        check_eq({31'h0, wr_refused}, 32'h1, "refused");
        rd_reg(REG_SECURITY_CONFIG, v);
        check_eq(v, 32'h8000_0000, "locked");
        otp_word = 32'hffff_ffff;
        @(posedge mclk);
        #1 otp_load = 1'b1;
        @(posedge mclk);
        #1 otp_load = 1'b0;
        rd_reg(REG_SECURITY_CONFIG, v);
        check_eq(v, 32'h8000_5fb1, "otp copy");
        do_reset();
        rd_reg(REG_SECURITY_CONFIG, v);
        check_eq(v, 32'h0, "sec after reset");
    endtask : t_security

    task automatic t_ring();
        wr_reg(REG_RING_OSC_CONTROL, 32'hffff_ffff);
        rd_reg(REG_RING_OSC_CONTROL, v);
        check_eq(v, 32'h3, "ring control");
        check_eq({30'h0, ring_osc_en}, 32'h3, "ring enables");
        repeat (40) @(posedge mclk);
        wr_reg(REG_RING_OSC_CONTROL, 32'h0);
        repeat (10) @(posedge mclk);
        for (int i = 0; i < 4; i++) begin
            rd_reg(REG_RING_OSC_VALUE0 + 8'(i), v);
            cnt_a[i] = v[15:0];
            check_eq({31'h0, v[15:0] != 16'h0 && v[31:16] === 16'h0}, 32'h1, "ring ran");
        end
        wr_reg(REG_RING_OSC_CONTROL, 32'h1);
        repeat (40) @(posedge mclk);
        wr_reg(REG_RING_OSC_CONTROL, 32'h0);
        repeat (10) @(posedge mclk);
        do_reset();
        // peripheral pair ran alone; counts also kept through reset
        for (int i = 0; i < 4; i++) begin
            rd_reg(REG_RING_OSC_VALUE0 + 8'(i), v);
            check_eq({31'h0, v[15:0] == cnt_a[i]}, {31'h0, i < 2}, "ring select");
        end
    endtask : t_ring

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (12) @(posedge mclk);
        #1 srst = 1'b0;
        t_tile();
        t_boot_unmapped();
        t_security();
        t_ring();
        print_verdict();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        $display("BAD %0t run timed out", $time);
        print_verdict();
    end
endmodule : tb
